//--- uart_pkg.sv
// Shared constants, register map and helpers for both UART ends.
// Assumes one 10 MHz core clock on each end.
package uart_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_STD = 19200;
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_STD = DIV_W'(CLK_HZ / BAUD_STD);
    localparam int BRK_TIMEOUT_US = 10000;
    localparam int BRK_TIMEOUT_CYC = BRK_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int DATA_W = 8;
    localparam int FRAME_W = 12;
    localparam logic [3:0] BITS_BASE = 4'hA;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_TX_DATA = 8'h10;
    localparam logic [7:0] OFF_RX_DATA = 8'h14;
    localparam logic [7:0] OFF_BRK_TIMEOUT = 8'h18;

    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_PAR_LSB = 16;
    localparam int CTRL_STOP2 = 18;
    localparam int CTRL_FLOW = 19;
    localparam int CTRL_BRK_TX = 20;
    localparam int CTRL_RX_EN = 21;
    localparam logic [31:0] CTRL_RESET = 32'h0020_0000 | 32'(DIV_STD);

    localparam int ST_TX_BUSY = 0;
    localparam int ST_RX_FULL = 1;
    localparam int ST_CTS = 2;
    localparam int ST_RTS = 3;
    localparam int ST_BRK = 4;
    localparam int ST_RX_LINE = 5;
    localparam int ST_TX_PEND = 6;

    localparam int IRQ_N = 10;
    localparam int IRQ_RX_READY = 0;
    localparam int IRQ_TX_EMPTY = 1;
    localparam int IRQ_TX_DONE = 2;
    localparam int IRQ_PARITY = 3;
    localparam int IRQ_FRAME = 4;
    localparam int IRQ_RX_OVR = 5;
    localparam int IRQ_BRK_DET = 6;
    localparam int IRQ_BRK_END = 7;
    localparam int IRQ_CTS_CHG = 8;
    localparam int IRQ_TX_OVR = 9;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } rx_state_e;

    // Start bit in bit 0, then data LSB first, parity, stop bits
    function automatic logic [FRAME_W-1:0] build_frame(
        input logic [DATA_W-1:0] d, input logic [1:0] par);
        logic pb;
        pb = (par == PAR_ODD) ? ~^d : ^d;
        build_frame = (par == PAR_NONE) ? {3'h7, d, 1'b0}
                                        : {2'h3, pb, d, 1'b0};
    endfunction : build_frame

    function automatic logic [3:0] frame_bits(
        input logic [1:0] par, input logic stop2);
        frame_bits = BITS_BASE + {3'h0, par != PAR_NONE} + {3'h0, stop2};
    endfunction : frame_bits
endpackage : uart_pkg

//--- uart_link_if.sv
// Serial link between the device end and the host end.
// Undriven lines resolve high, as with the usual pull-ups.
`timescale 1ns/10ps
interface uart_link_if;
    logic dev_tx;
    logic dev_tx_oe;
    logic dev_rts_n;
    logic dev_rts_oe;
    logic host_tx;
    logic host_tx_oe;
    logic host_rts_n;
    logic host_rts_oe;
    logic dev_rx_line;
    logic host_rx_line;
    logic dev_cts_n;
    logic host_cts_n;

    // One line per direction, crossed over
    assign dev_rx_line = host_tx_oe ? host_tx : 1'b1;
    assign host_rx_line = dev_tx_oe ? dev_tx : 1'b1;
    assign dev_cts_n = host_rts_oe ? host_rts_n : 1'b1;
    assign host_cts_n = dev_rts_oe ? dev_rts_n : 1'b1;

    modport device (
        output dev_tx, dev_tx_oe, dev_rts_n, dev_rts_oe,
        input dev_rx_line, dev_cts_n
    );
    modport host (
        output host_tx, host_tx_oe, host_rts_n, host_rts_oe,
        input host_rx_line, host_cts_n
    );
endinterface : uart_link_if

//--- serial_frame_rx.sv
// Receive deserialiser: one character per frame, sampled mid-bit.
// Assumes rx_i is already synchronised to core_clk_i.
`timescale 1ns/10ps
module serial_frame_rx
    import uart_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Line and settings
    input wire logic rx_i,
    input wire logic [DIV_W-1:0] div_i,
    input wire logic [1:0] parity_i,
    // Received character
    output logic valid_o,
    output logic [DATA_W-1:0] data_o,
    output logic parity_err_o,
    output logic frame_err_o
);
    rx_state_e state;
    logic [DIV_W-1:0] cnt;
    logic [2:0] bitn;
    logic [DATA_W-1:0] shift;
    logic par_acc;
    logic perr;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state <= RX_IDLE;
            cnt <= '0;
            bitn <= 3'h0;
            shift <= '0;
            par_acc <= 1'b0;
            perr <= 1'b0;
            valid_o <= 1'b0;
            data_o <= '0;
            parity_err_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            valid_o <= 1'b0;
            if (state != RX_IDLE && cnt != '0) begin
                cnt <= cnt - 1'b1;
            end else begin
                case (state)
                    RX_IDLE: if (!rx_i) begin
                        cnt <= div_i >> 1;
                        state <= RX_START;
                    end
                    RX_START: begin
                        // A start bit gone by mid-bit was a glitch
                        state <= rx_i ? RX_IDLE : RX_DATA;
                        cnt <= div_i - 1'b1;
                        bitn <= 3'h0;
                        par_acc <= 1'b0;
                    end
                    RX_DATA: begin
                        shift <= {rx_i, shift[DATA_W-1:1]};
                        par_acc <= par_acc ^ rx_i;
                        bitn <= bitn + 1'b1;
                        cnt <= div_i - 1'b1;
                        if (bitn == 3'h7) begin
                            state <= (parity_i == PAR_NONE) ? RX_STOP
                                                            : RX_PARITY;
                        end
                    end
                    RX_PARITY: begin
                        perr <= (par_acc ^ rx_i) != (parity_i == PAR_ODD);
                        cnt <= div_i - 1'b1;
                        state <= RX_STOP;
                    end
                    RX_STOP: begin
                        data_o <= shift;
                        valid_o <= 1'b1;
                        frame_err_o <= ~rx_i;
                        parity_err_o <= (parity_i != PAR_NONE) & perr;
                        perr <= 1'b0;
                        state <= RX_IDLE;
                    end
                    default: state <= RX_IDLE;
                endcase
            end
        end
    end
endmodule : serial_frame_rx

//--- uart_device_end.sv
// Device end of the UART: APB registers, transmitter, receiver,
// break reset detector, break sender and interrupt status.
// Assumes one core clock; link pins arrive through uart_link_if.
//
// Function
// - Full-duplex serial to parallel and back
// - Ten interrupt types toward the processor
// - One serial data line per direction
// - Active-low flow control on rts and cts
// - Host stops sending while rts deasserted
// - Selectable baud, parity, stop bits, flow
// - Long low on input resets the system
// - Sustained low output sends a break
// - Outputs tristated while held in reset
// - Sharing devices release pins after reset
`timescale 1ns/10ps
module uart_device_end
    import uart_pkg::*;
#(
    parameter int BRK_TIMEOUT_DEFAULT = BRK_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // System
    output logic irq_o,
    output logic sys_reset_req_o,
    // Serial link
    uart_link_if.device link
);
    logic rx_meta, rx_sync, cts_meta, cts_sync, cts_prev;
    logic [31:0] ctrl, brk_timeout, brk_cnt, next_rdata, status;
    logic brk_active, brk_hit, tx_pend, rx_full, rts_n_q;
    logic [IRQ_N-1:0] irq_stat, irq_mask, ev;
    logic [DATA_W-1:0] tx_hold, rx_data, rx_word;
    logic [DIV_W-1:0] div, tx_cnt;
    logic [1:0] parity;
    logic stop2, flow_en, brk_tx, rx_en, cts_ok;
    logic acc, wr, rd, hit, rx_valid, rx_perr, rx_ferr, rd_rx, rx_ovr;
    logic tx_wr, tx_start, tx_busy, tx_done, tx_q;
    logic [FRAME_W-2:0] tx_shift;
    logic [3:0] tx_left;

    assign div = ctrl[CTRL_DIV_LSB +: DIV_W];
    assign parity = ctrl[CTRL_PAR_LSB +: 2];
    assign stop2 = ctrl[CTRL_STOP2];
    assign flow_en = ctrl[CTRL_FLOW];
    assign brk_tx = ctrl[CTRL_BRK_TX];
    assign rx_en = ctrl[CTRL_RX_EN];
    assign cts_ok = ~flow_en | ~cts_sync;

    // Pins come from another device: two flops before use
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
            cts_prev <= 1'b1;
        end else begin
            rx_meta <= link.dev_rx_line;
            rx_sync <= rx_meta;
            cts_meta <= link.dev_cts_n;
            cts_sync <= cts_meta;
            cts_prev <= cts_sync;
        end
    end

    // APB: zero-wait access phase, read data captured at setup
    assign acc = psel_i & penable_i;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;
    assign pready_o = acc;
    assign pslverr_o = acc & ~hit;

    always_comb begin
        status = 32'h0;
        status[ST_TX_BUSY] = tx_busy;
        status[ST_RX_FULL] = rx_full;
        status[ST_CTS] = ~cts_sync;
        status[ST_RTS] = ~rts_n_q;
        status[ST_BRK] = brk_active;
        status[ST_RX_LINE] = rx_sync;
        status[ST_TX_PEND] = tx_pend;
    end

    always_comb begin
        next_rdata = 32'h0;
        hit = 1'b1;
        if (paddr_i == OFF_CTRL) begin
            next_rdata = ctrl;
        end else if (paddr_i == OFF_STATUS) begin
            next_rdata = status;
        end else if (paddr_i == OFF_IRQ_STAT) begin
            next_rdata = 32'(irq_stat);
        end else if (paddr_i == OFF_IRQ_MASK) begin
            next_rdata = 32'(irq_mask);
        end else if (paddr_i == OFF_TX_DATA) begin
            next_rdata = 32'(tx_hold);
        end else if (paddr_i == OFF_RX_DATA) begin
            next_rdata = 32'(rx_data);
        end else if (paddr_i == OFF_BRK_TIMEOUT) begin
            next_rdata = brk_timeout;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctrl <= CTRL_RESET;
            brk_timeout <= 32'(BRK_TIMEOUT_DEFAULT);
            irq_mask <= '0;
        end else if (wr) begin
            if (paddr_i == OFF_CTRL) begin
                ctrl <= pwdata_i;
            end else if (paddr_i == OFF_IRQ_MASK) begin
                irq_mask <= pwdata_i[IRQ_N-1:0];
            end else if (paddr_i == OFF_BRK_TIMEOUT) begin
                brk_timeout <= pwdata_i;
            end
        end
    end

    // Receiver; a new character into a full buffer is dropped unless the buffer is read that cycle
    serial_frame_rx u_rx (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .rx_i(rx_sync),
        .div_i(div),
        .parity_i(parity),
        .valid_o(rx_valid),
        .data_o(rx_word),
        .parity_err_o(rx_perr),
        .frame_err_o(rx_ferr)
    );

    assign rd_rx = rd & (paddr_i == OFF_RX_DATA);
    assign rx_ovr = rx_valid & rx_full & ~rd_rx;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_full <= 1'b0;
            rx_data <= '0;
            rts_n_q <= 1'b1;
        end else begin
            if (rx_valid & (~rx_full | rd_rx)) begin
                rx_full <= 1'b1;
                rx_data <= rx_word;
            end else if (rd_rx) begin
                rx_full <= 1'b0;
            end
            // With flow control on, ready to take data only with room for it
            rts_n_q <= ~(rx_en & (~flow_en | ~rx_full));
        end
    end

    // Transmitter; writes while a character is pending are refused
    assign tx_wr = wr & (paddr_i == OFF_TX_DATA);
    assign tx_start = tx_pend & ~tx_busy & cts_ok & ~brk_tx;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tx_pend <= 1'b0;
            tx_hold <= '0;
        end else if (tx_wr & ~tx_pend) begin
            tx_pend <= 1'b1;
            tx_hold <= pwdata_i[DATA_W-1:0];
        end else if (tx_start) begin
            tx_pend <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tx_busy <= 1'b0;
            tx_done <= 1'b0;
            tx_q <= 1'b1;
            tx_shift <= '0;
            tx_left <= 4'h0;
            tx_cnt <= '0;
        end else begin
            tx_done <= 1'b0;
            if (tx_start) begin
                {tx_shift, tx_q} <= build_frame(tx_hold, parity);
                tx_left <= frame_bits(parity, stop2) - 1'b1;
                tx_cnt <= div - 1'b1;
                tx_busy <= 1'b1;
            end else if (tx_busy && tx_cnt != '0) begin
                tx_cnt <= tx_cnt - 1'b1;
            end else if (tx_busy && tx_left == 4'h0) begin
                tx_busy <= 1'b0;
                tx_done <= 1'b1;
            end else if (tx_busy) begin
                tx_q <= tx_shift[0];
                tx_shift <= tx_shift >> 1;
                tx_left <= tx_left - 1'b1;
                tx_cnt <= div - 1'b1;
            end
        end
    end

    // Break detector; a zero timeout disables the reset request
    assign brk_hit = ~rx_sync & ~brk_active & (brk_timeout != 32'h0)
                   & (brk_cnt == brk_timeout);
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            brk_cnt <= 32'h0;
            brk_active <= 1'b0;
            sys_reset_req_o <= 1'b0;
        end else begin
            sys_reset_req_o <= brk_hit;
            if (rx_sync) begin
                brk_cnt <= 32'h0;
                brk_active <= 1'b0;
            end else if (brk_hit) begin
                brk_active <= 1'b1;
            end else if (!brk_active) begin
                brk_cnt <= brk_cnt + 1'b1;
            end
        end
    end

    // Interrupt events; a set in the clearing cycle wins
    always_comb begin
        ev = '0;
        ev[IRQ_RX_READY] = rx_valid & ~rx_ovr;
        ev[IRQ_TX_EMPTY] = tx_start;
        ev[IRQ_TX_DONE] = tx_done;
        ev[IRQ_PARITY] = rx_valid & rx_perr;
        ev[IRQ_FRAME] = rx_valid & rx_ferr;
        ev[IRQ_RX_OVR] = rx_ovr;
        ev[IRQ_BRK_DET] = brk_hit;
        ev[IRQ_BRK_END] = rx_sync & brk_active;
        ev[IRQ_CTS_CHG] = cts_sync ^ cts_prev;
        ev[IRQ_TX_OVR] = tx_wr & tx_pend;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            irq_stat <= '0;
        end else if (wr && paddr_i == OFF_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~pwdata_i[IRQ_N-1:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // Break forces the line low for as long as software holds it
    assign link.dev_tx = tx_q & ~brk_tx;
    assign link.dev_tx_oe = rst_b_i;
    assign link.dev_rts_n = rts_n_q;
    assign link.dev_rts_oe = rst_b_i;
endmodule : uart_device_end

//--- uart_host_end.sv
// Host end of the UART: stream in, stream out, break sender.
// Assumes one core clock; link pins arrive through uart_link_if.
`timescale 1ns/10ps
module uart_host_end
    import uart_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Line settings
    input wire logic [DIV_W-1:0] divisor_i,
    input wire logic [1:0] parity_i,
    input wire logic stop2_i,
    input wire logic flow_en_i,
    // Pin drive, readiness and break
    input wire logic drive_en_i,
    input wire logic recv_ready_i,
    input wire logic send_break_i,
    // Send stream
    input wire logic send_valid_i,
    input wire logic [DATA_W-1:0] send_data_i,
    output logic send_ready_o,
    // Receive stream
    output logic recv_valid_o,
    output logic [DATA_W-1:0] recv_data_o,
    output logic recv_parity_err_o,
    output logic recv_frame_err_o,
    // Serial link
    uart_link_if.host link
);
    logic rx_meta;
    logic rx_sync;
    logic cts_meta;
    logic cts_sync;
    logic brk_q;
    logic rts_n_q;
    logic tx_start;
    logic tx_busy;
    logic tx_q;
    logic [FRAME_W-2:0] tx_shift;
    logic [3:0] tx_left;
    logic [DIV_W-1:0] tx_cnt;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
            brk_q <= 1'b0;
            rts_n_q <= 1'b1;
        end else begin
            rx_meta <= link.host_rx_line;
            rx_sync <= rx_meta;
            cts_meta <= link.host_cts_n;
            cts_sync <= cts_meta;
            brk_q <= send_break_i;
            rts_n_q <= ~recv_ready_i;
        end
    end

    // Hold off while the device has its request-to-send deasserted
    assign send_ready_o = ~tx_busy & ~brk_q
                        & (~flow_en_i | ~cts_sync);
    assign tx_start = send_valid_i & send_ready_o;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tx_busy <= 1'b0;
            tx_q <= 1'b1;
            tx_shift <= '0;
            tx_left <= 4'h0;
            tx_cnt <= '0;
        end else if (tx_start) begin
            {tx_shift, tx_q} <= build_frame(send_data_i, parity_i);
            tx_left <= frame_bits(parity_i, stop2_i) - 1'b1;
            tx_cnt <= divisor_i - 1'b1;
            tx_busy <= 1'b1;
        end else if (tx_busy && tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 1'b1;
        end else if (tx_busy && tx_left == 4'h0) begin
            tx_busy <= 1'b0;
        end else if (tx_busy) begin
            tx_q <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_left <= tx_left - 1'b1;
            tx_cnt <= divisor_i - 1'b1;
        end
    end

    serial_frame_rx u_rx (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .rx_i(rx_sync),
        .div_i(divisor_i),
        .parity_i(parity_i),
        .valid_o(recv_valid_o),
        .data_o(recv_data_o),
        .parity_err_o(recv_parity_err_o),
        .frame_err_o(recv_frame_err_o)
    );

    // Break may cut a frame short; the device sees a framing error
    assign link.host_tx = tx_q & ~brk_q;
    assign link.host_tx_oe = drive_en_i;
    assign link.host_rts_n = rts_n_q;
    assign link.host_rts_oe = drive_en_i;
endmodule : uart_host_end

//--- uart_link_props.sv
// Link checker: bit timing, pin release and line resolution.
// Assumes both ends run a bit divisor of 8 on one clock.
`timescale 1ns/10ps
module uart_link_props (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Device pins
    input wire logic dev_tx,
    input wire logic dev_tx_oe,
    input wire logic dev_rts_n,
    input wire logic dev_rts_oe,
    // Host pins
    input wire logic host_tx,
    input wire logic host_tx_oe,
    input wire logic host_rts_n,
    input wire logic host_rts_oe,
    // Resolved lines
    input wire logic dev_rx_line,
    input wire logic host_rx_line,
    input wire logic dev_cts_n,
    input wire logic host_cts_n
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Repetition counts assume divisor 8
    chk_dev_low_bit: assert property ($fell(dev_tx) |-> !dev_tx [*8])
        else $error("device low bit too short");
    chk_dev_high_bit: assert property ($rose(dev_tx) |-> dev_tx [*8])
        else $error("device high bit too short");
    chk_host_low_bit: assert property ($fell(host_tx) |-> !host_tx [*8])
        else $error("host low bit too short");
    chk_host_high_bit: assert property ($rose(host_tx) |-> host_tx [*8])
        else $error("host high bit too short");
    chk_oe_pair: assert property (dev_tx_oe == dev_rts_oe)
        else $error("device enables differ");
    chk_rx_resolve: assert property (host_tx_oe |-> dev_rx_line == host_tx)
        else $error("device rx line not host tx");
    chk_host_released: assert property (!host_tx_oe |-> dev_rx_line)
        else $error("released host line not high");
    chk_cts_resolve: assert property (dev_rts_oe |-> host_cts_n == dev_rts_n)
        else $error("host cts not device rts");
    cover property ($fell(dev_tx));
    cover property ($fell(host_tx));
    cover property ($rose(dev_rts_n));
endmodule : uart_link_props

//--- uart_with_break_reset_tb.sv
// Bench: both UART ends joined; APB drives the device end.
// Assumes divisor 8 on both ends and a short break timeout.
`timescale 1ns/10ps
module uart_with_break_reset_tb;
    import uart_pkg::*;
    logic core_clk = 0, rst_b = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, irq, sys_rst_req, err;
    logic [15:0] divisor = 16'h0008;
    logic [1:0] parity = 0;
    logic stop2 = 0, flow_en = 1, drive_en = 0, recv_ready = 1;
    logic send_break = 0, send_valid = 0, send_ready, recv_valid;
    logic [7:0] send_data = 0, recv_data, b;
    logic recv_par_err, recv_frm_err;
    logic [7:0] exp_q[$];
    int mismatches = 0, checks_done = 0, cyc = 0, n;
    uart_link_if i_uart_link_if ();
    uart_device_end #(.BRK_TIMEOUT_DEFAULT(200)) i_uart_device_end (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .sys_reset_req_o(sys_rst_req),
        .link(i_uart_link_if.device));
    uart_host_end i_uart_host_end (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .divisor_i(divisor),
        .parity_i(parity), .stop2_i(stop2), .flow_en_i(flow_en),
        .drive_en_i(drive_en), .recv_ready_i(recv_ready),
        .send_break_i(send_break), .send_valid_i(send_valid),
        .send_data_i(send_data), .send_ready_o(send_ready),
        .recv_valid_o(recv_valid), .recv_data_o(recv_data),
        .recv_parity_err_o(recv_par_err), .recv_frame_err_o(recv_frm_err),
        .link(i_uart_link_if.host));
    uart_link_props i_uart_link_props (
        .core_clk_i(core_clk), .rst_b_i(rst_b),
        .dev_tx(i_uart_link_if.dev_tx), .dev_tx_oe(i_uart_link_if.dev_tx_oe),
        .dev_rts_n(i_uart_link_if.dev_rts_n),
        .dev_rts_oe(i_uart_link_if.dev_rts_oe),
        .host_tx(i_uart_link_if.host_tx),
        .host_tx_oe(i_uart_link_if.host_tx_oe),
        .host_rts_n(i_uart_link_if.host_rts_n),
        .host_rts_oe(i_uart_link_if.host_rts_oe),
        .dev_rx_line(i_uart_link_if.dev_rx_line),
        .host_rx_line(i_uart_link_if.host_rx_line),
        .dev_cts_n(i_uart_link_if.dev_cts_n),
        .host_cts_n(i_uart_link_if.host_cts_n));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic host_send(input logic [7:0] d);
        @(posedge core_clk);
        send_valid <= 1'b1;
        send_data <= d;
        @(posedge core_clk);
        while (send_ready !== 1'b1) @(posedge core_clk);
        send_valid <= 1'b0;
    endtask : host_send
    // Break characters arrive as frame errors and carry no data
    always @(posedge core_clk) begin
        if (recv_valid === 1'b1 && recv_frm_err !== 1'b1) begin
            check({23'h0, recv_par_err, recv_data},
                  exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'h1FF);
        end
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h907fc5cc));
        repeat (2) @(posedge core_clk);
        check({31'h0, i_uart_link_if.dev_tx_oe}, 32'h0);
        rst_b <= 1'b1;
        drive_en <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        check(rd, CTRL_RESET);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, OFF_IRQ_MASK, 32'h41);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            parity <= i[1:0];
            stop2 <= i[0];
            apb(1'b1, OFF_CTRL, {10'h0, 3'h5, i[0], i[1:0], 16'h0008});
            b = 8'($urandom());
            exp_q.push_back(b);
            apb(1'b1, OFF_TX_DATA, {24'h0, b});
            b = 8'($urandom());
            host_send(b);
            n = 0;
            do begin
                apb(1'b0, OFF_STATUS, 32'h0);
                n++;
            end while (rd[ST_RX_FULL] !== 1'b1 && n < 100);
            check({31'h0, i_uart_link_if.dev_rts_n}, 32'h1);
            check({31'h0, irq}, 32'h1);
            apb(1'b0, OFF_RX_DATA, 32'h0);
            check(rd, {24'h0, b});
            apb(1'b1, OFF_IRQ_STAT, 32'h3FF);
            // The clear lands at the access edge; look one edge later
            @(posedge core_clk);
            check({31'h0, irq}, 32'h0);
            check({31'h0, i_uart_link_if.dev_rts_n}, 32'h0);
            for (n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge core_clk);
            check(32'(exp_q.size()), 32'h0);
        end
        $display("test traffic done");
        parity <= PAR_NONE;
        stop2 <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h0030_0008);
        repeat (20) @(posedge core_clk);
        check({31'h0, i_uart_link_if.host_rx_line}, 32'h0);
        // Break held until reset: a short one would end in a clean stop
        apb(1'b0, OFF_CTRL, 32'h0);
        check(rd, 32'h0030_0008);
        repeat (200) @(posedge core_clk);
        send_break <= 1'b1;
        for (n = 0; n < 300 && sys_rst_req !== 1'b1; n++) @(posedge core_clk);
        check({31'h0, n >= 200 && n <= 215}, 32'h1);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        send_break <= 1'b0;
        rst_b <= 1'b0;
        drive_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({31'h0, i_uart_link_if.dev_tx_oe}, 32'h0);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        drive_en <= 1'b1;
        repeat (4) @(posedge core_clk);
        $display("test break done");
        wrap_up();
    end
endmodule : uart_with_break_reset_tb
